// >>> hdl/hwpc_map.svh
`ifndef HWPC_MAP_SVH
`define HWPC_MAP_SVH
`define HWPC_CFG_MGMT_EN_BIT     1
`define HWPC_CFG_INT_EN_BIT      2
`define HWPC_CFG_NMI_MODE_BIT    5
`define HWPC_MMASK_CHAIN_BIT     6
`define HWPC_MMASK2_RESET_BIT    7
`define HWPC_NMASK2_CLR_BIT      7
`define HWPC_PULSE_MS            20
`define HWPC_CLK_KHZ             125000
`define HWPC_PULSE_CYCLES        (`HWPC_PULSE_MS * `HWPC_CLK_KHZ)
`define HWPC_CNT_W               22
`define HWPC_VID_REG_ADDR        3'h7
`define HWPC_CFG_RESET           8'h00
`define HWPC_SYNC_W              15
`endif

// >>> hdl/hwpc_pkg.sv
package hwpc_pkg;
  typedef struct packed
  {
    logic [7:0] cfg;
    logic [7:0] mgmt_mask;
    logic [7:0] mgmt_mask2;
    logic [7:0] nmi_mask2;
  } hwpc_ctrl_t;
  typedef struct packed
  {
    logic o;
    logic oe;
  } hwpc_pin_t;
  typedef enum logic [1:0]
  {
    HWPC_IDLE  = 2'b00,
    HWPC_PULSE = 2'b01,
    HWPC_WAIT  = 2'b10
  } hwpc_pulse_state_t;
endpackage

// >>> hdl/hwpc_pulse.sv
`timescale 1ns/1ps
`default_nettype none
`include "hwpc_map.svh"
module hwpc_pulse
#(
  parameter int unsigned PULSE_CYCLES = `HWPC_PULSE_CYCLES
)
(
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic fire,
  output logic      active
);
  hwpc_pkg::hwpc_pulse_state_t     state;
  hwpc_pkg::hwpc_pulse_state_t     next_state;
  logic [`HWPC_CNT_W-1:0]          cnt;
  logic [`HWPC_CNT_W-1:0]          next_cnt;
  logic                            next_active;

  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_active = 1'b0;
    case (state)
      hwpc_pkg::HWPC_IDLE:
      begin
        if (fire)
        begin
          next_state  = hwpc_pkg::HWPC_PULSE;
          next_cnt    = PULSE_CYCLES[`HWPC_CNT_W-1:0] - 22'h00_0001;
          next_active = 1'b1;
        end
      end
      hwpc_pkg::HWPC_PULSE:
      begin
        next_active = 1'b1;
        if (cnt == '0)
        begin
          next_state  = hwpc_pkg::HWPC_WAIT;
          next_active = 1'b0;
        end
        else
          next_cnt = cnt - 22'h00_0001;
      end
      hwpc_pkg::HWPC_WAIT:
      begin
        // Rearm only after the trigger drops
        if (!fire)
          next_state = hwpc_pkg::HWPC_IDLE;
      end
      default:
        next_state = hwpc_pkg::HWPC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state  <= hwpc_pkg::HWPC_IDLE;
      cnt    <= '0;
      active <= 1'b0;
    end
    else
    begin
      state  <= next_state;
      cnt    <= next_cnt;
      active <= next_active;
    end
  end
endmodule
`default_nettype wire

// >>> hdl/hwpc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hwpc_map.svh"
module hwpc_top
#(
  parameter int unsigned PULSE_CYCLES = `HWPC_PULSE_CYCLES
)
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire hwpc_pkg::hwpc_ctrl_t ctrl,
  input  wire logic               int_event,
  input  wire logic               mgmt_event,
  input  wire logic               reset_fire,
  input  wire logic               intrusion_clear,
  input  wire logic               chip_sel_n,
  input  wire logic [2:0]         low_addr_bits,
  input  wire logic               io_rd_n,
  input  wire logic               io_wr_n,
  input  wire logic [3:0]         voltage_id_inputs,
  input  wire logic               chained_mgmt_irq_in_n,
  input  wire logic               board_overtemp_in_n,
  input  wire logic               ser_clk_in,
  input  wire logic               ser_data_in,
  input  wire logic               ser_data_drive_low,
  input  wire logic               intrusion_in,
  output logic                    bus_sel,
  output logic                    bus_rd,
  output logic                    bus_wr,
  output logic [2:0]              bus_addr,
  output logic [7:0]              vid_read_data,
  output logic                    vid_read_valid,
  output logic                    board_overtemp,
  output logic                    ser_clk,
  output logic                    ser_data,
  output logic                    ser_data_o,
  output logic                    ser_data_oe,
  output logic                    int_pin_o,
  output logic                    int_pin_oe,
  output logic                    sys_mgmt_irq_out_o,
  output logic                    sys_mgmt_irq_out_oe,
  output logic                    master_reset_o,
  output logic                    master_reset_oe,
  output logic                    intrusion_o,
  output logic                    intrusion_oe,
  output logic                    board_test_tree_out
);
  // ==========================================================
  // Pin input synchronisers
  // ==========================================================
  logic [`HWPC_SYNC_W-1:0] sync1;
  logic [`HWPC_SYNC_W-1:0] sync2;
  logic [`HWPC_SYNC_W-1:0] sync3;
  logic [`HWPC_SYNC_W-1:0] stable;
  logic [`HWPC_SYNC_W-1:0] next_stable;
  logic [`HWPC_SYNC_W-1:0] raw_in;

  assign raw_in = {chip_sel_n, low_addr_bits, io_rd_n, io_wr_n, voltage_id_inputs,
                   chained_mgmt_irq_in_n, board_overtemp_in_n, ser_clk_in, ser_data_in, intrusion_in};

  genvar gi;
  generate
    for (gi = 0; gi < `HWPC_SYNC_W; gi++)
    begin : g_sync
      always_comb
      begin
        next_stable[gi] = stable[gi];
        if (sync2[gi] == sync3[gi])
          next_stable[gi] = sync3[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Idle levels: select, address and read strobe high, write strobe low; VID bit 0, chain, overtemp and clock inputs high, data input low
      sync1  <= 15'h7_C3C;
      sync2  <= 15'h7_C3C;
      sync3  <= 15'h7_C3C;
      stable <= 15'h7_C3C;
    end
    else
    begin
      sync1  <= raw_in;
      sync2  <= sync1;
      sync3  <= sync2;
      stable <= next_stable;
    end
  end

  logic       s_cs_n;
  logic [2:0] s_addr;
  logic       s_rd_n;
  logic       s_wr_n;
  logic [3:0] s_vid;
  logic       s_chain_n;
  logic       s_bti_n;
  logic       s_scl;
  logic       s_sda;
  logic       s_intr;

  assign {s_cs_n, s_addr, s_rd_n, s_wr_n, s_vid, s_chain_n, s_bti_n, s_scl, s_sda, s_intr} = stable;

  // ==========================================================
  // Pulse timers for master reset and intrusion clear
  // ==========================================================
  logic reset_active;
  logic intr_active;
  logic reset_trig;
  logic intr_trig;

  assign reset_trig = reset_fire & ctrl.mgmt_mask2[`HWPC_MMASK2_RESET_BIT];
  assign intr_trig  = intrusion_clear & ctrl.nmi_mask2[`HWPC_NMASK2_CLR_BIT];

  hwpc_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_reset_pulse
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fire    (reset_trig),
    .active  (reset_active)
  );

  hwpc_pulse #(.PULSE_CYCLES(PULSE_CYCLES)) u_intr_pulse
  (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .fire    (intr_trig),
    .active  (intr_active)
  );

  // ==========================================================
  // Host bus decode
  // ==========================================================
  logic       next_bus_sel;
  logic       next_bus_rd;
  logic       next_bus_wr;
  logic [2:0] next_bus_addr;

  always_comb
  begin
    next_bus_sel  = ~s_cs_n;
    next_bus_rd   = ~s_cs_n & ~s_rd_n;
    next_bus_wr   = ~s_cs_n & ~s_wr_n;
    next_bus_addr = s_addr;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_sel  <= 1'b0;
      bus_rd   <= 1'b0;
      bus_wr   <= 1'b0;
      bus_addr <= 3'h0;
    end
    else
    begin
      bus_sel  <= next_bus_sel;
      bus_rd   <= next_bus_rd;
      bus_wr   <= next_bus_wr;
      bus_addr <= next_bus_addr;
    end
  end

  // ==========================================================
  // Voltage-ID readback
  // ==========================================================
  logic [7:0] next_vid_read_data;
  logic       next_vid_read_valid;
  logic       prev_rd_n;
  logic       next_prev_rd_n;
  logic       vid_read_hit;

  always_comb
  begin
    // Capture on the falling read strobe to the VID register
    vid_read_hit        = ~s_cs_n & ~s_rd_n & prev_rd_n & (s_addr == `HWPC_VID_REG_ADDR);
    next_prev_rd_n      = s_rd_n;
    next_vid_read_data  = vid_read_data;
    next_vid_read_valid = 1'b0;
    if (vid_read_hit)
    begin
      next_vid_read_data  = {4'h0, s_vid};
      next_vid_read_valid = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vid_read_data  <= 8'h00;
      vid_read_valid <= 1'b0;
      prev_rd_n      <= 1'b1;
    end
    else
    begin
      vid_read_data  <= next_vid_read_data;
      vid_read_valid <= next_vid_read_valid;
      prev_rd_n      <= next_prev_rd_n;
    end
  end

  // ==========================================================
  // Interrupt pins
  // ==========================================================
  logic int_en;
  logic nmi_mode;
  logic mgmt_en;
  logic mgmt_req;
  logic next_int_o;
  logic next_int_oe;
  logic next_mgmt_oe;

  always_comb
  begin
    int_en       = ctrl.cfg[`HWPC_CFG_INT_EN_BIT];
    nmi_mode     = ctrl.cfg[`HWPC_CFG_NMI_MODE_BIT];
    mgmt_en      = ctrl.cfg[`HWPC_CFG_MGMT_EN_BIT];
    mgmt_req     = mgmt_event | (~s_chain_n & ctrl.mgmt_mask[`HWPC_MMASK_CHAIN_BIT]);
    // NMI drives high (open source), IRQ pulls low (open drain)
    next_int_o   = nmi_mode;
    next_int_oe  = int_en & int_event;
    next_mgmt_oe = mgmt_en & mgmt_req;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_pin_o           <= 1'b0;
      int_pin_oe          <= 1'b0;
      sys_mgmt_irq_out_oe <= 1'b0;
    end
    else
    begin
      int_pin_o           <= next_int_o;
      int_pin_oe          <= next_int_oe;
      sys_mgmt_irq_out_oe <= next_mgmt_oe;
    end
  end

  // ==========================================================
  // Pulse, serial bus and test pins
  // ==========================================================
  logic next_rst_oe;
  logic next_intr_oe;
  logic next_board_overtemp;
  logic next_ser_clk;
  logic next_ser_data;
  logic next_sda_oe;
  logic next_tree;

  always_comb
  begin
    next_rst_oe         = reset_active;
    next_intr_oe        = intr_active;
    next_board_overtemp = ~s_bti_n;
    next_ser_clk        = s_scl;
    next_ser_data       = s_sda;
    next_sda_oe         = ser_data_drive_low;
    next_tree           = ~(&stable);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      master_reset_oe     <= 1'b0;
      intrusion_oe        <= 1'b0;
      board_overtemp      <= 1'b0;
      ser_clk             <= 1'b1;
      ser_data            <= 1'b1;
      ser_data_oe         <= 1'b0;
      board_test_tree_out <= 1'b0;
    end
    else
    begin
      master_reset_oe     <= next_rst_oe;
      intrusion_oe        <= next_intr_oe;
      board_overtemp      <= next_board_overtemp;
      ser_clk             <= next_ser_clk;
      ser_data            <= next_ser_data;
      ser_data_oe         <= next_sda_oe;
      board_test_tree_out <= next_tree;
    end
  end

  // ==========================================================
  // Open-drain data levels
  // ==========================================================
  logic next_od_low;

  always_comb
  begin
    // Open-drain pins only pull low; the enables carry the state
    next_od_low = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ser_data_o         <= 1'b0;
      sys_mgmt_irq_out_o <= 1'b0;
      master_reset_o     <= 1'b0;
      intrusion_o        <= 1'b0;
    end
    else
    begin
      ser_data_o         <= next_od_low;
      sys_mgmt_irq_out_o <= next_od_low;
      master_reset_o     <= next_od_low;
      intrusion_o        <= next_od_low;
    end
  end
endmodule
`default_nettype wire

// >>> verification/hwpc_chk.sv
`timescale 1ns/1ps
`default_nettype none
module hwpc_chk
#(
  parameter int unsigned PULSE_CYCLES = 20
)
(
  input wire logic                 clk_sys,
  input wire logic                 rst_n,
  input wire hwpc_pkg::hwpc_ctrl_t ctrl,
  input wire logic                 int_event,
  input wire logic                 mgmt_event,
  input wire logic                 reset_fire,
  input wire logic                 intrusion_clear,
  input wire logic [7:0]           vid_read_data,
  input wire logic                 vid_read_valid,
  input wire logic                 int_pin_o,
  input wire logic                 int_pin_oe,
  input wire logic                 sys_mgmt_irq_out_oe,
  input wire logic                 master_reset_oe,
  input wire logic                 intrusion_oe
);
  int unsigned rst_run;
  int unsigned clr_run;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==========
  // Pulse run counters
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_run <= 0;
      clr_run <= 0;
    end
    else
    begin
      rst_run <= master_reset_oe ? rst_run + 1 : 0;
      clr_run <= intrusion_oe ? clr_run + 1 : 0;
    end
  end
  int_on_a: assert property (ctrl.cfg[2] && int_event |=> int_pin_oe) else $error("irq off");
  int_off_a: assert property (!ctrl.cfg[2] |=> !int_pin_oe) else $error("irq on");
  int_mode_a: assert property ($changed(ctrl.cfg[5]) |=> int_pin_o == $past(ctrl.cfg[5])) else $error("mode");
  mgmt_off_a: assert property (!ctrl.cfg[1] |=> !sys_mgmt_irq_out_oe) else $error("mgmt on");
  chain_gate_a: assert property (!ctrl.mgmt_mask[6] && !mgmt_event |=> !sys_mgmt_irq_out_oe) else $error("chain");
  rst_start_a: assert property ($rose(master_reset_oe) |->
    $past(ctrl.mgmt_mask2[7], 2) && $past(reset_fire, 2)) else $error("reset start");
  rst_len_a: assert property ($fell(master_reset_oe) |-> rst_run == PULSE_CYCLES) else $error("reset len");
  clr_start_a: assert property ($rose(intrusion_oe) |->
    $past(ctrl.nmi_mask2[7], 2) && $past(intrusion_clear, 2)) else $error("clear start");
  clr_len_a: assert property ($fell(intrusion_oe) |-> clr_run == PULSE_CYCLES) else $error("clear len");
  vid_pulse_a: assert property (vid_read_valid |-> vid_read_data[7:4] == 4'h0 ##1 !vid_read_valid)
    else $error("vid");
endmodule
bind hwpc_top hwpc_chk #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk
(
  .clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl), .int_event(int_event), .mgmt_event(mgmt_event),
  .reset_fire(reset_fire), .intrusion_clear(intrusion_clear), .vid_read_data(vid_read_data),
  .vid_read_valid(vid_read_valid), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe),
  .sys_mgmt_irq_out_oe(sys_mgmt_irq_out_oe), .master_reset_oe(master_reset_oe), .intrusion_oe(intrusion_oe)
);
`default_nettype wire

// >>> verification/hwpc_host.sv
`timescale 1ns/1ps
`default_nettype none
module hwpc_host
(
  input  wire logic       clk_sys,
  input  wire logic       int_pin_o,
  input  wire logic       int_pin_oe,
  input  wire logic       sensor_hot,
  output logic            chip_sel_n,
  output logic [2:0]      low_addr_bits,
  output logic            io_rd_n,
  output logic            io_wr_n,
  output logic            board_overtemp_in_n,
  output logic            int_line
);
  // ==========
  // Pulled pin levels
  assign int_line = int_pin_oe ? int_pin_o : !int_pin_o;
  assign board_overtemp_in_n = !sensor_hot;
  initial
  begin
    chip_sel_n = 1'b1;
    low_addr_bits = 3'h0;
    io_rd_n = 1'b1;
    io_wr_n = 1'b1;
  end
  task automatic isa_read(input logic [2:0] a, input logic cs_n);
    @(posedge clk_sys);
    #1;
    chip_sel_n = cs_n;
    low_addr_bits = a;
    io_rd_n = 1'b0;
    repeat (8) @(posedge clk_sys);
    #1;
    io_rd_n = 1'b1;
    repeat (8) @(posedge clk_sys);
    #1;
    chip_sel_n = 1'b1;
    low_addr_bits = ~a;
  endtask
endmodule
`default_nettype wire

// >>> verification/hwpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hwpc_top_tb;
  localparam int unsigned PULSE = 20;
  logic clk_sys = 1'b0, rst_n = 1'b0, int_event = 1'b1, mgmt_event = 1'b1, chain_n = 1'b1, sclk = 1'b1;
  logic sdata = 1'b1, intr_in = 1'b1, sdrive = 1'b0, sensor_hot = 1'b0, cs_n, rd_n, wr_n, bti_n, int_line;
  logic vid_read_valid, board_overtemp, ser_clk, ser_data, ser_data_oe, int_pin_o, int_pin_oe;
  logic mgmt_oe, master_reset_oe, intrusion_oe, tree;
  logic bus_sel, bus_rd, bus_wr, sd_o, mgmt_o, rst_o, intr_o;
  logic [2:0] bus_addr;
  logic [1:0] fire = 2'h0;
  logic [3:0] vid = 4'h0;
  logic [2:0] addr;
  logic [7:0] vid_read_data;
  logic [7:0] exp_q[$];
  hwpc_pkg::hwpc_ctrl_t ctrl = '0;
  int fails = 0, n_tests = 0;
  always #4 clk_sys = ~clk_sys;
  hwpc_top #(.PULSE_CYCLES(PULSE)) DUT
  (
    .clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl), .int_event(int_event), .mgmt_event(mgmt_event),
    .reset_fire(fire[0]), .intrusion_clear(fire[1]), .chip_sel_n(cs_n), .low_addr_bits(addr),
    .io_rd_n(rd_n), .io_wr_n(wr_n), .voltage_id_inputs(vid), .chained_mgmt_irq_in_n(chain_n),
    .board_overtemp_in_n(bti_n), .ser_clk_in(sclk), .ser_data_in(sdata), .ser_data_drive_low(sdrive),
    .intrusion_in(intr_in), .bus_sel(bus_sel), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_addr(bus_addr),
    .vid_read_data(vid_read_data), .vid_read_valid(vid_read_valid), .board_overtemp(board_overtemp),
    .ser_clk(ser_clk), .ser_data(ser_data), .ser_data_o(sd_o), .ser_data_oe(ser_data_oe),
    .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .sys_mgmt_irq_out_o(mgmt_o), .sys_mgmt_irq_out_oe(mgmt_oe),
    .master_reset_o(rst_o), .master_reset_oe(master_reset_oe), .intrusion_o(intr_o), .intrusion_oe(intrusion_oe),
    .board_test_tree_out(tree)
  );
  hwpc_host host
  (
    .clk_sys(clk_sys), .int_pin_o(int_pin_o), .int_pin_oe(int_pin_oe), .sensor_hot(sensor_hot),
    .chip_sel_n(cs_n), .low_addr_bits(addr), .io_rd_n(rd_n), .io_wr_n(wr_n),
    .board_overtemp_in_n(bti_n), .int_line(int_line)
  );
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ==========
  // Read result watcher
  always @(negedge clk_sys)
  begin
    if (vid_read_valid === 1'b1)
    begin
      chk(vid_read_data, exp_q.size() ? exp_q.pop_front() : 8'hff);
      chk({bus_sel, bus_rd, bus_wr, bus_addr}, 8'h37);
    end
  end
  initial
  begin
    int n;
    void'($urandom(28566));
    ctrl.cfg = 8'hff;
    cyc(3);
    chk({int_pin_oe, int_pin_o, mgmt_oe}, 8'h00);
    cyc(3);
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      ctrl.cfg = {2'h0, i[1], 2'h0, i[0], 2'h0};
      cyc(1);
      chk({int_pin_oe, int_pin_o, int_line, mgmt_oe}, {i[0], i[1], i[0] ? i[1] : !i[1], 1'b0});
    end
    mgmt_event = 1'b0;
    chain_n = 1'b0;
    for (int j = 0; j < 4; j++)
    begin
      ctrl.cfg[1] = j[0];
      ctrl.mgmt_mask[6] = j[1];
      cyc(8);
      chk(mgmt_oe, j == 3);
    end
    for (int k = 0; k < 4; k++)
    begin
      n = 0;
      ctrl.mgmt_mask2[7] = k[0];
      ctrl.nmi_mask2[7] = k[0];
      fire = k[1] ? 2'h2 : 2'h1;
      for (int i = 0; i < 60; i++)
      begin
        if (i == 40)
          fire = 2'h0;
        cyc(1);
        n += k[1] ? intrusion_oe : master_reset_oe;
      end
      chk(8'(n), k[0] ? 8'(PULSE) : 8'h00);
    end
    for (int k = 0; k < 3; k++)
    begin
      vid = 4'($urandom);
      exp_q.push_back({4'h0, vid});
      cyc(6);
      host.isa_read(3'h7, 1'b0);
    end
    host.isa_read(3'h7, 1'b1);
    host.isa_read(3'h0, 1'b0);
    {sdrive, sensor_hot, sclk, sdata} = 4'hc;
    cyc(8);
    chk({ser_data_oe, board_overtemp, ser_clk, ser_data, tree}, 8'h19);
    {sdrive, sensor_hot, sclk, sdata, chain_n, vid} = 9'h07f;
    cyc(8);
    chk(tree, 8'h00);
    vid = 4'he;
    cyc(8);
    chk(tree, 8'h01);
    chk(8'(exp_q.size()), 8'h00);
    chk({sd_o, mgmt_o, rst_o, intr_o}, 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
